// >>> hdl/sfcs_seq.sv
// Summary of operation
// RULE1 - Identification sends 0x9F then clocks in exactly three identity bytes.
// RULE2 - Status read sends 0x05 then clocks in one status byte.
// RULE3 - Status bit 0 is the busy flag and bit 1 the write-enable latch.
// RULE4 - Write enable sends 0x06 then repeats status reads until the latch reads set.
// RULE5 - Chip erase sends 0xC7 then reads status until busy reads clear.
// RULE6 - Data read sends 0x03, a three-byte address, then the requested byte count.
// RULE7 - Page program sends 0x02, a three-byte address, then 1 to 255 data bytes.
// RULE8 - Sector erase sends 0x20 and a 4K-aligned address, then polls until not busy.
// RULE9 - The attached flash accepts and executes all these command sequences.
// RULE10 - The discoverable parameter table of the flash can be read.
// RULE11 - The file area always starts at flash address zero.
// RULE12 - Files take 4KB blocks, at least one; fail-safe files double, at least 8KB.
// RULE13 - At most 128 files and at most 16MB per file.
// RULE14 - Raw accesses into the file area are refused; only the file manager reaches it.
// RULE15 - A write-enable sequence precedes every program and erase command.
// RULE16 - Each sequence is framed by one chip-select assertion, released between them.
`timescale 1ns/1ps
module sfcs_seq (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic link_clk,
    input wire logic rstn,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire sfcs_pkg::sfcs_op_t cmd_op,
    input wire logic [23:0] cmd_addr,
    input wire logic [7:0] cmd_len,
    input wire logic cmd_fs,
    // Completion
    output logic done,
    output logic err,
    output logic [7:0] status,
    output logic [23:0] flash_id,
    // Program data
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    // Read data
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    // File area
    input wire logic [12:0] fs_blocks,
    input wire logic [24:0] alloc_len,
    input wire logic alloc_failsafe,
    input wire logic [7:0] alloc_count,
    output logic [13:0] alloc_blocks,
    output logic alloc_ok,
    // Flash pins
    output logic fl_cs_n,
    output logic fl_sclk,
    output logic fl_mosi,
    input wire logic fl_miso
);
    typedef enum logic [3:0] {
        S_IDLE, S_WREN, S_WCHK, S_WRD, S_OP, S_ADDR, S_DUMMY, S_DATA,
        S_PCHK, S_PRD, S_FIN
    } sfcs_st_t;

    typedef enum logic [1:0] {L_IDLE, L_HI, L_LO} sfcs_lst_t;

    typedef struct packed {
        sfcs_st_t st;
        sfcs_pkg::sfcs_op_t op;
        logic [23:0] addr;
        logic [7:0] len;
        logic [7:0] cnt;
        logic wt;
        logic req;
        logic [7:0] tx;
        logic last;
        logic ack_s1;
        logic ack_s2;
        logic ack_d;
        logic push;
        logic [7:0] rxd;
        logic bad;
        logic cmd_rdy;
        logic wr_rdy;
        logic done;
        logic err;
        logic [7:0] status;
        logic [23:0] id;
        logic wel_ok;
        logic [2:0] hcnt;
        logic [13:0] ablk;
        logic aok;
    } sfcs_core_t;

    typedef struct packed {
        sfcs_lst_t st;
        logic rq1;
        logic rq2;
        logic seen;
        logic [7:0] sh;
        logic [7:0] rx;
        logic [2:0] bc;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic ack;
    } sfcs_link_t;

    sfcs_core_t s_r, s_nxt;
    sfcs_link_t l_r, l_nxt;
    logic buf_rdy;
    logic ack;
    logic take;
    logic go;
    logic glast;
    logic [7:0] gtx;
    logic in_fs;
    logic [24:0] fs_end;
    logic [25:0] up;
    logic [13:0] nb;
    localparam logic [7:0] STAT_ONE = sfcs_pkg::STAT_BYTES;

    function automatic logic needs_wren(input sfcs_pkg::sfcs_op_t op);
        return op == sfcs_pkg::OP_PROG || op == sfcs_pkg::OP_SE
            || op == sfcs_pkg::OP_CE;
    endfunction

    function automatic logic is_rd(input sfcs_pkg::sfcs_op_t op);
        return op == sfcs_pkg::OP_READ || op == sfcs_pkg::OP_SFDP;
    endfunction

    function automatic logic [7:0] opcode(input sfcs_pkg::sfcs_op_t op);
        case (op)
            sfcs_pkg::OP_ID: return sfcs_pkg::OPC_ID;
            sfcs_pkg::OP_STAT: return sfcs_pkg::OPC_STAT;
            sfcs_pkg::OP_WREN: return sfcs_pkg::OPC_WREN;
            sfcs_pkg::OP_CE: return sfcs_pkg::OPC_CE;
            sfcs_pkg::OP_READ: return sfcs_pkg::OPC_READ;
            sfcs_pkg::OP_PROG: return sfcs_pkg::OPC_PROG;
            sfcs_pkg::OP_SE: return sfcs_pkg::OPC_SE;
            default: return sfcs_pkg::OPC_SFDP;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Sequencer, ref_clk domain

    assign ack = s_r.ack_s2 ^ s_r.ack_d;
    assign take = cmd_valid && s_r.cmd_rdy;
    assign fs_end = 25'(sfcs_pkg::FS_BASE) + (25'(fs_blocks) << sfcs_pkg::BLOCK_BITS);
    assign in_fs = 25'(cmd_addr) >= 25'(sfcs_pkg::FS_BASE)
        && 25'(cmd_addr) < fs_end; // see RULE11
    assign up = 26'(alloc_len) + sfcs_pkg::BLOCK_MASK;

    always_comb begin
        s_nxt = s_r;
        go = 1'b0;
        glast = 1'b0;
        gtx = sfcs_pkg::FILL_BYTE;
        s_nxt.ack_s1 = l_r.ack;
        s_nxt.ack_s2 = s_r.ack_s1;
        s_nxt.ack_d = s_r.ack_s2;
        s_nxt.push = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.err = 1'b0;
        if (ack) begin
            s_nxt.wt = 1'b0;
            s_nxt.rxd = l_r.rx;
        end
        case (s_r.st)
            S_IDLE: begin
                if (take) begin
                    s_nxt.op = cmd_op;
                    s_nxt.addr = cmd_addr;
                    s_nxt.len = cmd_len;
                    s_nxt.wel_ok = 1'b0;
                    s_nxt.bad = 1'b0;
                    if (cmd_op == sfcs_pkg::OP_SE) begin
                        s_nxt.addr[sfcs_pkg::SECTOR_BITS-1:0] = '0; // see RULE8
                    end
                    if ((cmd_op == sfcs_pkg::OP_PROG || is_rd(cmd_op)) && cmd_len == '0) begin
                        s_nxt.bad = 1'b1; // see RULE7
                    end
                    if (!cmd_fs && ((cmd_op != sfcs_pkg::OP_CE && cmd_op != sfcs_pkg::OP_ID
                        && cmd_op != sfcs_pkg::OP_STAT && cmd_op != sfcs_pkg::OP_WREN
                        && in_fs) || (cmd_op == sfcs_pkg::OP_CE && fs_blocks != '0))) begin
                        s_nxt.bad = 1'b1; // see RULE14
                    end
                    if (s_nxt.bad) begin
                        s_nxt.st = S_FIN;
                    end else if (needs_wren(cmd_op) || cmd_op == sfcs_pkg::OP_WREN) begin
                        s_nxt.st = S_WREN; // see RULE15
                    end else begin
                        s_nxt.st = S_OP;
                    end
                end
            end
            S_WREN: begin
                if (!s_r.wt) begin
                    go = 1'b1;
                    gtx = sfcs_pkg::OPC_WREN; // see RULE4
                    glast = 1'b1;
                end else if (ack) begin
                    s_nxt.st = S_WCHK;
                end
            end
            S_WCHK, S_PCHK: begin
                if (!s_r.wt) begin
                    go = 1'b1;
                    gtx = sfcs_pkg::OPC_STAT; // see RULE2
                end else if (ack) begin
                    s_nxt.st = (s_r.st == S_WCHK) ? S_WRD : S_PRD;
                end
            end
            S_WRD: begin
                if (!s_r.wt) begin
                    go = 1'b1;
                    glast = 1'b1;
                end else if (ack) begin
                    s_nxt.status = l_r.rx;
                    if (l_r.rx[sfcs_pkg::WEL_BIT]) begin // see RULE3
                        s_nxt.wel_ok = 1'b1;
                        s_nxt.st = (s_r.op == sfcs_pkg::OP_WREN) ? S_FIN : S_OP;
                    end else begin
                        s_nxt.st = S_WCHK; // see RULE4
                    end
                end
            end
            S_PRD: begin
                if (!s_r.wt) begin
                    go = 1'b1;
                    glast = 1'b1;
                end else if (ack) begin
                    s_nxt.status = l_r.rx;
                    // Flash keeps busy set until its own operation ends
                    if (l_r.rx[sfcs_pkg::BUSY_BIT]) begin // see RULE9
                        s_nxt.st = S_PCHK; // see RULE5
                    end else begin
                        s_nxt.st = S_FIN; // see RULE3
                    end
                end
            end
            S_OP: begin
                if (!s_r.wt) begin
                    go = 1'b1;
                    gtx = opcode(s_r.op); // see RULE6
                    glast = s_r.op == sfcs_pkg::OP_CE; // see RULE5
                    s_nxt.wel_ok = 1'b0;
                    s_nxt.cnt = '0;
                end else if (ack) begin
                    case (s_r.op)
                        sfcs_pkg::OP_ID: begin
                            s_nxt.cnt = sfcs_pkg::ID_BYTES; // see RULE1
                            s_nxt.st = S_DATA;
                        end
                        sfcs_pkg::OP_STAT: begin
                            s_nxt.cnt = sfcs_pkg::STAT_BYTES; // see RULE2
                            s_nxt.st = S_DATA;
                        end
                        sfcs_pkg::OP_CE: s_nxt.st = S_PCHK;
                        default: s_nxt.st = S_ADDR;
                    endcase
                end
            end
            S_ADDR: begin
                if (!s_r.wt) begin
                    go = 1'b1;
                    gtx = s_r.addr[sfcs_pkg::ADDR_W-1-sfcs_pkg::BYTE_W*s_r.cnt[1:0] -: 8];
                    glast = s_r.op == sfcs_pkg::OP_SE && s_r.cnt == sfcs_pkg::ADDR_LAST;
                end else if (ack) begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                    if (s_r.cnt == sfcs_pkg::ADDR_LAST) begin
                        s_nxt.cnt = s_r.len;
                        case (s_r.op)
                            sfcs_pkg::OP_SE: s_nxt.st = S_PCHK; // see RULE8
                            sfcs_pkg::OP_SFDP: s_nxt.st = S_DUMMY; // see RULE10
                            default: s_nxt.st = S_DATA; // see RULE6
                        endcase
                    end
                end
            end
            S_DUMMY: begin
                if (!s_r.wt) begin
                    go = 1'b1;
                end else if (ack) begin
                    s_nxt.st = S_DATA;
                end
            end
            S_DATA: begin
                if (!s_r.wt) begin
                    glast = s_r.cnt == STAT_ONE;
                    if (s_r.op == sfcs_pkg::OP_PROG) begin
                        go = wr_valid && s_r.wr_rdy; // see RULE7
                        gtx = wr_data;
                    end else if (is_rd(s_r.op)) begin
                        // Only fetch a byte once the buffer can hold it
                        go = buf_rdy && !s_r.push;
                    end else begin
                        go = 1'b1;
                    end
                end else if (ack) begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                    if (s_r.op == sfcs_pkg::OP_ID) begin
                        s_nxt.id = {s_r.id[15:0], l_r.rx}; // see RULE1
                    end
                    if (s_r.op == sfcs_pkg::OP_STAT) begin
                        s_nxt.status = l_r.rx;
                    end
                    s_nxt.push = is_rd(s_r.op);
                    if (s_r.cnt == STAT_ONE) begin
                        s_nxt.st = (s_r.op == sfcs_pkg::OP_PROG) ? S_PCHK : S_FIN;
                    end
                end
            end
            S_FIN: begin
                s_nxt.done = 1'b1;
                s_nxt.err = s_r.bad;
                s_nxt.st = S_IDLE;
            end
            default: s_nxt.st = S_IDLE;
        endcase
        if (go) begin
            s_nxt.tx = gtx;
            s_nxt.last = glast; // see RULE16
            s_nxt.req = ~s_r.req;
            s_nxt.wt = 1'b1;
            s_nxt.hcnt = glast ? '0 : s_r.hcnt + 1'b1;
        end
        s_nxt.cmd_rdy = s_nxt.st == S_IDLE;
        s_nxt.wr_rdy = s_nxt.st == S_DATA && s_nxt.op == sfcs_pkg::OP_PROG && !s_nxt.wt;
        // File allocation size check
        nb = 14'(up >> sfcs_pkg::BLOCK_BITS);
        if (nb < sfcs_pkg::MIN_BLOCKS) begin
            nb = sfcs_pkg::MIN_BLOCKS;
        end
        if (alloc_failsafe) begin
            nb = nb << 1; // see RULE12
            if (nb < sfcs_pkg::MIN_FS_BLOCKS) begin
                nb = sfcs_pkg::MIN_FS_BLOCKS;
            end
        end
        s_nxt.ablk = nb;
        s_nxt.aok = alloc_count < sfcs_pkg::MAX_FILES
            && alloc_len <= sfcs_pkg::MAX_FILE_LEN; // see RULE13
    end


    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{st: S_IDLE, op: sfcs_pkg::OP_ID, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    sfcs_buf #(
        .WIDTH(sfcs_pkg::BYTE_W),
        .DEPTH(sfcs_pkg::BUF_DEPTH)
    ) u_buf (
        .clk(ref_clk),
        .rstn(rstn),
        .in_valid(s_r.push),
        .in_ready(buf_rdy),
        .in_data(s_r.rxd),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    assign cmd_ready = s_r.cmd_rdy;
    assign wr_ready = s_r.wr_rdy;
    assign done = s_r.done;
    assign err = s_r.err;
    assign status = s_r.status;
    assign flash_id = s_r.id;
    assign alloc_blocks = s_r.ablk;
    assign alloc_ok = s_r.aok;

    ////////////////////////////////////////////////////////////////////
    // Byte shifter, link_clk domain; tx and last stay still until ack

    always_comb begin
        l_nxt = l_r;
        l_nxt.rq1 = s_r.req;
        l_nxt.rq2 = l_r.rq1;
        case (l_r.st)
            L_IDLE: begin
                if (l_r.rq2 != l_r.seen) begin
                    l_nxt.sh = s_r.tx;
                    l_nxt.cs_n = 1'b0; // see RULE16
                    l_nxt.mosi = s_r.tx[sfcs_pkg::BYTE_MSB];
                    l_nxt.bc = '0;
                    l_nxt.st = L_HI;
                end
            end
            L_HI: begin
                l_nxt.sclk = 1'b1;
                l_nxt.st = L_LO;
            end
            L_LO: begin
                l_nxt.sclk = 1'b0;
                l_nxt.rx = {l_r.rx[sfcs_pkg::BYTE_MSB-1:0], fl_miso};
                if (l_r.bc == sfcs_pkg::BIT_LAST) begin
                    l_nxt.ack = ~l_r.ack;
                    l_nxt.seen = l_r.rq2;
                    l_nxt.cs_n = s_r.last; // see RULE16
                    l_nxt.st = L_IDLE;
                end else begin
                    l_nxt.sh = l_r.sh << 1;
                    l_nxt.mosi = l_r.sh[sfcs_pkg::BYTE_MSB-1];
                    l_nxt.bc = l_r.bc + 1'b1;
                    l_nxt.st = L_HI;
                end
            end
            default: l_nxt.st = L_IDLE;
        endcase
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            l_r <= '{st: L_IDLE, cs_n: 1'b1, default: '0};
        end else begin
            l_r <= l_nxt;
        end
    end

    assign fl_cs_n = l_r.cs_n;
    assign fl_sclk = l_r.sclk;
    assign fl_mosi = l_r.mosi;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    id_three_bytes_a: assert property ( // see RULE1
        go && glast && s_r.st == S_DATA && s_r.op == sfcs_pkg::OP_ID |-> s_r.hcnt == 3'h3)
        else $error("identity frame not three bytes");
    stat_one_byte_a: assert property ( // see RULE2
        go && glast && s_r.st == S_DATA && s_r.op == sfcs_pkg::OP_STAT |-> s_r.hcnt == 3'h1)
        else $error("status frame not one byte");
    busy_clear_a: assert property ( // see RULE3
        ack && s_r.st == S_PRD && !l_r.rx[0] |=> s_r.st == S_FIN ##1 done)
        else $error("busy clear did not finish");
    wel_repoll_a: assert property ( // see RULE4
        ack && s_r.st == S_WRD && !l_r.rx[1] |=> s_r.st == S_WCHK)
        else $error("latch clear did not repoll");
    chip_erase_a: assert property ( // see RULE5
        go && s_r.st == S_OP && s_r.op == sfcs_pkg::OP_CE |-> glast && gtx == 8'hC7)
        else $error("chip erase frame wrong");
    opcode_byte_a: assert property ( // see RULE6
        go && s_r.st == S_OP && s_r.op == sfcs_pkg::OP_READ |-> gtx == 8'h03)
        else $error("wrong opcode sent");
    zero_len_a: assert property ( // see RULE7
        take && cmd_op == sfcs_pkg::OP_PROG && cmd_len == 8'h00 |-> ##2 done && err)
        else $error("zero length program accepted");
    sector_align_a: assert property ( // see RULE8
        s_r.st == S_ADDR && s_r.op == sfcs_pkg::OP_SE |-> s_r.addr[11:0] == 12'h000)
        else $error("sector address not aligned");
    wren_before_a: assert property ( // see RULE15
        go && s_r.st == S_OP && needs_wren(s_r.op) |-> s_r.wel_ok)
        else $error("program or erase without write enable");
    raw_guard_a: assert property ( // see RULE14
        take && !cmd_fs && cmd_op == sfcs_pkg::OP_CE && fs_blocks != '0 |-> ##2 err)
        else $error("raw erase of file area accepted");
    file_cap_a: assert property ( // see RULE13
        alloc_count >= 8'h80 |=> !alloc_ok)
        else $error("file count over limit accepted");
    failsafe_min_a: assert property ( // see RULE12
        alloc_failsafe |=> alloc_blocks >= 14'h0002)
        else $error("fail-safe file under two blocks");
    cs_frame_a: assert property ( // see RULE16
        @(posedge link_clk) disable iff (!rstn) l_r.sclk |-> !l_r.cs_n)
        else $error("clock pulse outside chip select");

    read_seen_c: cover property (take && cmd_op == sfcs_pkg::OP_READ);
    poll_seen_c: cover property (ack && s_r.st == S_PRD && l_r.rx[0]);
    prog_seen_c: cover property (wr_valid && s_r.wr_rdy);
endmodule

// >>> hdl/sfcs_pkg.sv
package sfcs_pkg;
    // Flash opcodes
    localparam logic [7:0] OPC_ID = 8'h9F;
    localparam logic [7:0] OPC_STAT = 8'h05;
    localparam logic [7:0] OPC_WREN = 8'h06;
    localparam logic [7:0] OPC_CE = 8'hC7;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_PROG = 8'h02;
    localparam logic [7:0] OPC_SE = 8'h20;
    localparam logic [7:0] OPC_SFDP = 8'h5A;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    // Status byte fields
    localparam int BUSY_BIT = 0;
    localparam int WEL_BIT = 1;
    // Frame layout
    localparam int BYTE_W = 8;
    localparam int BYTE_MSB = 7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] ID_BYTES = 8'h03;
    localparam logic [7:0] STAT_BYTES = 8'h01;
    localparam logic [7:0] ADDR_LAST = 8'h02;
    localparam int ADDR_W = 24;
    localparam int SECTOR_BITS = 12;
    // File area
    localparam logic [23:0] FS_BASE = 24'h00_0000;
    localparam int BLOCK_BITS = 12;
    localparam logic [25:0] BLOCK_MASK = 26'h000_0FFF;
    localparam logic [13:0] MIN_BLOCKS = 14'h0001;
    localparam logic [13:0] MIN_FS_BLOCKS = 14'h0002;
    localparam logic [7:0] MAX_FILES = 8'h80;
    localparam logic [24:0] MAX_FILE_LEN = 25'h100_0000;
    // Read buffer
    localparam int BUF_DEPTH = 2;

    typedef enum logic [2:0] {
        OP_ID, OP_STAT, OP_WREN, OP_CE, OP_READ, OP_PROG, OP_SE, OP_SFDP
    } sfcs_op_t;
endpackage

// >>> hdl/sfcs_buf.sv
`timescale 1ns/1ps
module sfcs_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0] cnt;
        logic rdy;
        logic ov;
    } sfcs_buf_t;

    sfcs_buf_t s_r, s_nxt;

    // Head always sits in entry 0 so the output is a plain flop
    always_comb begin
        s_nxt = s_r;
        if (s_r.ov && out_ready) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_nxt.mem[i] = s_r.mem[i+1];
            end
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
        if (in_valid && s_r.rdy) begin
            s_nxt.mem[s_nxt.cnt] = in_data;
            s_nxt.cnt = s_nxt.cnt + 1'b1;
        end
        s_nxt.rdy = s_nxt.cnt != CW'(DEPTH);
        s_nxt.ov = s_nxt.cnt != '0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{mem: '0, cnt: '0, rdy: 1'b1, ov: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign in_ready = s_r.rdy;
    assign out_valid = s_r.ov;
    assign out_data = s_r.mem[0];
endmodule

// >>> verif/sfcs_flash_model.sv
`timescale 1ns/1ps
module sfcs_flash_model #(
    parameter logic [23:0] ID = 24'h5A_C3E1 // Arbitrary identity value
) (
    // Flash pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // Observation
    output logic [23:0] addr = 24'h00_0000,
    output logic [7:0] nbytes = 8'h00,
    output logic [7:0] bad = 8'h00
);
    logic [7:0] sr = 8'h00, tx = 8'h00, n = 8'h00, bi = 8'h00, op = 8'h00;
    logic [2:0] bc = 3'h0;
    logic [1:0] bcnt = 2'h0;
    logic wel = 1'b0, wpend = 1'b0, busy = 1'b0, mo = 1'b0;
    // Released line shows the inverse of the last bit
    assign miso = cs_n ? ~mo : mo;
    always @(negedge cs_n) begin
        bi = 8'h00;
        bc = 3'h0;
        n = 8'h00;
    end
    always @(posedge sclk) begin
        sr = {sr[6:0], mosi};
        bc = bc + 3'h1;
        if (bc == 3'h0) begin
            if (bi == 8'h00) op = sr;
            else if (bi < 8'h04 && op inside {8'h03, 8'h02, 8'h20, 8'h5A}) addr = {addr[15:0], sr};
            else if (op == 8'h02) n = n + 8'h01;
            bi = bi + 8'h01;
            tx = (op == 8'h9F) ? 8'(ID >> (24 - 8 * bi)) :
                (op == 8'h05) ? {6'h00, wel, busy} : 8'(addr[7:0] + bi);
        end
    end
    always @(negedge sclk) begin
        mo <= tx[7];
        tx <= {tx[6:0], 1'b0};
    end
    always @(posedge cs_n) begin
        if (bc != 3'h0) bad = bad + 8'h01;
        if (op == 8'h06) wpend = 1'b1;
        if (op inside {8'h02, 8'h20, 8'hC7}) begin
            if (!wel) bad = bad + 8'h01;
            busy = 1'b1;
            wel = 1'b0;
            bcnt = 2'h2;
        end
        if (op == 8'h02) nbytes = n;
        if (op == 8'h05) begin
            // Latch settles a poll late and busy three polls late, so polls must repeat
            wel = wel | wpend;
            wpend = 1'b0;
            if (bcnt == 2'h0) busy = 1'b0;
            else bcnt = bcnt - 2'h1;
        end
    end
endmodule

// >>> verif/serial_flash_command_sequencer_bench.sv
`timescale 1ns/1ps
module serial_flash_command_sequencer_bench;
    localparam logic [23:0] FID = 24'h5A_C3E1;
    logic ref_clk = 1'b0, link_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_fs = 1'b0;
    logic wr_valid = 1'b0, rd_ready = 1'b0, alloc_failsafe = 1'b0;
    sfcs_pkg::sfcs_op_t cmd_op = sfcs_pkg::OP_ID;
    logic [23:0] cmd_addr = 24'h00_0000;
    logic [7:0] cmd_len = 8'h00, wr_data = 8'h00, alloc_count = 8'h00;
    logic [12:0] fs_blocks = 13'h0001;
    logic [24:0] alloc_len = 25'h000_0001;
    logic cmd_ready, done, err, wr_ready, rd_valid, alloc_ok, fl_cs_n, fl_sclk, fl_mosi, fl_miso;
    logic [7:0] status, rd_data, nbytes, bad;
    logic [23:0] flash_id, f_addr;
    logic [13:0] alloc_blocks;
    int errors = 0, checks_done = 0;
    always #12.5 ref_clk = ~ref_clk;
    always #15 link_clk = ~link_clk;
    sfcs_seq sfcs_seq_inst (.ref_clk, .link_clk, .rstn, .cmd_valid, .cmd_ready, .cmd_op,
        .cmd_addr, .cmd_len, .cmd_fs, .done, .err, .status, .flash_id, .wr_valid, .wr_ready,
        .wr_data, .rd_valid, .rd_ready, .rd_data, .fs_blocks, .alloc_len, .alloc_failsafe,
        .alloc_count, .alloc_blocks, .alloc_ok, .fl_cs_n, .fl_sclk, .fl_mosi, .fl_miso);
    sfcs_flash_model #(.ID(FID)) sfcs_flash_model_inst (.cs_n(fl_cs_n), .sclk(fl_sclk),
        .mosi(fl_mosi), .miso(fl_miso), .addr(f_addr), .nbytes, .bad);
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic run(input sfcs_pkg::sfcs_op_t o, input logic [23:0] a, input logic [7:0] n,
                       input logic fs, input logic e);
        int i;
        int k;
        logic d;
        logic ge;
        logic [7:0] b;
        k = 0;
        d = 1'b0;
        b = a[7:0] + ((o == sfcs_pkg::OP_SFDP) ? 8'h05 : 8'h04);
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_addr <= a;
        cmd_len <= n;
        cmd_fs <= fs;
        wr_valid <= (o == sfcs_pkg::OP_PROG) && n != 8'h00;
        for (i = 0; i < 9000 && (!d || rd_valid === 1'b1); i++) begin
            @(posedge ref_clk);
            ge = d ? ge : err;
            d = d | done;
            if (cmd_ready === 1'b1) cmd_valid <= 1'b0;
            if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
                k++;
                wr_data <= wr_data + 8'h01;
                if (k == int'(n)) wr_valid <= 1'b0;
            end
            if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
                chk("rd_data", 24'(b + 8'(k)), 24'(rd_data));
                k++;
            end
            // Hold off the reader so the buffer fills and the link stalls
            rd_ready <= (i > 400) || d;
        end
        if (d !== 1'b1) begin
            errors++;
            end_sim();
        end
        chk("err", 24'(e), 24'(ge));
        if (o inside {sfcs_pkg::OP_READ, sfcs_pkg::OP_SFDP} && !e) chk("rd_n", 24'(n), 24'(k));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_status();
        run(sfcs_pkg::OP_ID, 24'h00_0000, 8'h00, 1'b1, 1'b0);
        chk("flash_id", FID, flash_id);
        run(sfcs_pkg::OP_WREN, 24'h00_0000, 8'h00, 1'b1, 1'b0);
        run(sfcs_pkg::OP_STAT, 24'h00_0000, 8'h00, 1'b1, 1'b0);
        chk("status", 24'h00_0002, 24'(status));
        $display("test status done");
    endtask
    task automatic t_read();
        run(sfcs_pkg::OP_READ, 24'h00_1010, 8'h03, 1'b0, 1'b0);
        run(sfcs_pkg::OP_READ, 24'h00_0FF0, 8'h03, 1'b0, 1'b1);
        run(sfcs_pkg::OP_READ, 24'h00_1010, 8'h00, 1'b1, 1'b1);
        run(sfcs_pkg::OP_SFDP, 24'h00_0010, 8'h02, 1'b1, 1'b0);
        $display("test read done");
    endtask
    task automatic t_write();
        run(sfcs_pkg::OP_PROG, 24'h00_2040, 8'h03, 1'b1, 1'b0);
        chk("prog_n", 24'h00_0003, 24'(nbytes));
        chk("prog_addr", 24'h00_2040, f_addr);
        chk("status", 24'h00_0000, 24'(status));
        run(sfcs_pkg::OP_PROG, 24'h00_2040, 8'h00, 1'b1, 1'b1);
        run(sfcs_pkg::OP_SE, 24'h00_3456, 8'h00, 1'b1, 1'b0);
        chk("se_addr", 24'h00_3000, f_addr);
        fs_blocks <= 13'h0000;
        run(sfcs_pkg::OP_CE, 24'h00_0000, 8'h00, 1'b0, 1'b0);
        chk("status", 24'h00_0000, 24'(status));
        fs_blocks <= 13'h0001;
        run(sfcs_pkg::OP_CE, 24'h00_0000, 8'h00, 1'b0, 1'b1);
        chk("faults", 24'h00_0000, 24'(bad));
        $display("test write done");
    endtask
    task automatic t_alloc();
        alloc_len <= 25'h000_1001;
        alloc_count <= 8'h7F;
        repeat (2) @(posedge ref_clk);
        chk("blocks", 24'h00_0002, 24'(alloc_blocks));
        chk("ok", 24'h00_0001, 24'(alloc_ok));
        alloc_len <= 25'h000_0001;
        alloc_failsafe <= 1'b1;
        alloc_count <= 8'h80;
        repeat (2) @(posedge ref_clk);
        chk("blocks", 24'h00_0002, 24'(alloc_blocks));
        chk("ok", 24'h00_0000, 24'(alloc_ok));
        $display("test alloc done");
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_status();
        t_read();
        t_write();
        t_alloc();
        chk("frames", 24'h00_0000, 24'(bad));
        end_sim();
    end
endmodule
